// *** hw/flag_params.svh ***
/*
  Constants of the flag register and supervisory call unit: addresses,
  bit positions, reset values, opcodes, function and result codes.
  Assumes inclusion by bare name from the unit's source files.
*/
`ifndef FLAG_PARAMS_SVH
`define FLAG_PARAMS_SVH

// ==========================================================
// flag register
`define FLAG_REG_ADDR 8'hf7
`define FLAG_RESET 8'h02
`define FLAG_WRITABLE 8'hd7
`define FLAG_PAGE_MODE_MASK 8'hc0
`define FLAG_PM_HI 7
`define FLAG_PM_LO 6
`define FLAG_BANK_BIT 4
`define FLAG_CARRY_BIT 2
`define FLAG_ZERO_BIT 1
`define FLAG_GIE_BIT 0

// ==========================================================
// supervisory call
`define SVC_OPCODE 8'h00
`define FN_BOOT_RESET 8'h00
`define FN_BLOCK_FETCH 8'h01
`define FN_BLOCK_PROGRAM 8'h02
`define FN_BLOCK_CLEAR 8'h03
`define FN_TABLE_FETCH 8'h06
`define FN_CHECKSUM 8'h07
`define FN_TRIM_FIRST 8'h08
`define FN_TRIM_SECOND 8'h09
`define FIRST_CALL_KEY_EXPECTED 8'h3a
`define SECOND_CALL_KEY_SP_OFFSET 8'h03
`define FIRST_CALL_KEY_SRAM_ADDR 8'hf8
`define SECOND_CALL_KEY_SRAM_ADDR 8'hf9
`define RESULT_SUCCESS 8'h00
`define RESULT_PROTECTED 8'h01
`define RESULT_SW_RESET 8'h02
`define RESULT_FATAL 8'h03
`define ACC_RESET 8'h00

`endif

// *** hw/flag_pkg.sv ***
/*
  Types shared by the flag unit and its call checker.
  Assumes nothing beyond the params header.
*/
package flag_pkg;

  // ==========================================================
  // flag-logic operations
  typedef enum logic [1:0] {FLAG_AND, FLAG_OR, FLAG_XOR} flag_op_t;

  // ==========================================================
  // supervisory call sequencer
  typedef enum logic [2:0] {
    CALL_IDLE, CALL_FIRST_CALL_KEY, CALL_SECOND_CALL_KEY, CALL_CHECK, CALL_RUN, CALL_WB, CALL_HALT
  } call_state_t;

endpackage : flag_pkg

// *** hw/call_if.sv ***
/*
  Carrier between the flag unit and its call checker.
  Assumes both ends run on the same clock; no state inside.
*/
`timescale 1ns/10ps
`default_nettype none

interface call_if;
  logic [7:0] func_code;
  logic [7:0] first_call_key;
  logic [7:0] second_call_key;
  logic [7:0] stack_ptr;
  logic code_defined;
  logic is_boot;
  logic keys_ok;
  logic has_result;

  modport unit (
    output func_code, first_call_key, second_call_key, stack_ptr,
    input code_defined, is_boot, keys_ok, has_result
  );
  modport checker_end (
    input func_code, first_call_key, second_call_key, stack_ptr,
    output code_defined, is_boot, keys_ok, has_result
  );
endinterface : call_if

`default_nettype wire

// *** hw/call_checker.sv ***
/*
  Decodes a supervisory function code and checks both call keys.
  Assumes the unit presents the captured code, first key and stack pointer, and the second key live from SRAM.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flag_params.svh"

module call_checker (
  // link to the flag unit
  call_if.checker_end chk
);
  import flag_pkg::*;

  logic [7:0] second_call_key_expected;

  // ==========================================================
  // function decode
  always_comb
  begin
    chk.code_defined = 1'b0;
    unique case (chk.func_code)
      `FN_BOOT_RESET, `FN_BLOCK_FETCH, `FN_BLOCK_PROGRAM, `FN_BLOCK_CLEAR,
      `FN_TABLE_FETCH, `FN_CHECKSUM, `FN_TRIM_FIRST, `FN_TRIM_SECOND:
        chk.code_defined = 1'b1;
      default:
        chk.code_defined = 1'b0;
    endcase
  end

  // boot reset is picked by the code alone
  assign chk.is_boot = (chk.func_code == `FN_BOOT_RESET);

  // checksum and table fetch reuse the first key byte for data
  assign chk.has_result = (chk.func_code != `FN_CHECKSUM) &&
                          (chk.func_code != `FN_TABLE_FETCH);

  // ==========================================================
  // key check
  assign second_call_key_expected = 8'(chk.stack_ptr + `SECOND_CALL_KEY_SP_OFFSET);
  assign chk.keys_ok = (chk.first_call_key == `FIRST_CALL_KEY_EXPECTED) &&
                       (chk.second_call_key == second_call_key_expected);

endmodule : call_checker

`default_nettype wire

// *** hw/flag_unit.sv ***
/*
  Processor flag register with supervisory call entry sequencer.
  Assumes the core presents opcodes, accumulator and stack pointer on
  core_clk, an SRAM port with one cycle read latency and a ROM engine
  that answers each start with a done pulse and a result code.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flag_params.svh"

module flag_unit #(
  parameter int PAGE_W = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register read port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  output logic [8:0] reg_full_addr,
  output logic reg_rd_hit,
  output logic [7:0] reg_rdata,
  // flag-logic instructions and ALU results
  input wire logic flag_op_valid,
  input wire flag_pkg::flag_op_t flag_op,
  input wire logic [7:0] flag_op_mask,
  input wire logic carry_we,
  input wire logic carry_in,
  input wire logic zero_we,
  input wire logic zero_in,
  // interrupt entry
  input wire logic instr_boundary,
  input wire logic irq_req,
  output logic irq_take,
  output logic flags_push_valid,
  output logic [7:0] flags_push_data,
  // flag outputs
  output logic [1:0] page_mode,
  output logic register_bank_select,
  output logic carry_flag,
  output logic zero_flag,
  output logic global_interrupt_enable,
  // page pointers
  input wire logic [PAGE_W-1:0] current_page_pointer,
  input wire logic [PAGE_W-1:0] stack_page_pointer,
  input wire logic [PAGE_W-1:0] index_page_pointer,
  input wire logic [PAGE_W-1:0] indirect_read_page,
  input wire logic [PAGE_W-1:0] indirect_write_page,
  output logic [PAGE_W-1:0] direct_page,
  output logic [PAGE_W-1:0] indexed_page,
  output logic [PAGE_W-1:0] stack_page,
  output logic [PAGE_W-1:0] buffer_read_page,
  output logic [PAGE_W-1:0] buffer_write_page,
  // supervisory call request
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] stack_pointer,
  // parameter block in SRAM page zero
  output logic sram_rd,
  output logic sram_wr,
  output logic [7:0] sram_addr,
  output logic [7:0] sram_wdata,
  input wire logic [7:0] sram_rdata,
  // ROM engine
  output logic rom_start,
  output logic [7:0] rom_function,
  input wire logic rom_done,
  input wire logic [7:0] rom_result,
  // status
  output logic call_busy,
  output logic core_halted
);
  import flag_pkg::*;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] saved_flags_r;
  logic [7:0] op_result;
  logic [7:0] first_call_key_r;
  logic [7:0] func_r;
  logic [7:0] sp_r;
  logic boot_pending_r;
  logic push_valid_r;
  logic [7:0] push_data_r;
  logic rd_hit_r;
  logic [7:0] rdata_r;
  logic call_enter;
  logic restore_now;
  call_state_t state_r;
  call_if chk_bus ();

  // ==========================================================
  // call checker
  assign chk_bus.func_code = func_r;
  assign chk_bus.first_call_key = first_call_key_r;
  assign chk_bus.second_call_key = sram_rdata;
  assign chk_bus.stack_ptr = sp_r;
  call_checker u_checker (
    .chk (chk_bus)
  );

  // ==========================================================
  // flag register
  always_comb
  begin
    unique case (flag_op)
      FLAG_AND: op_result = flags_r & flag_op_mask;
      FLAG_OR: op_result = flags_r | flag_op_mask;
      FLAG_XOR: op_result = flags_r ^ flag_op_mask;
      default: op_result = flags_r;
    endcase
  end
  // reserved bits never stored, whatever software sends
  always_comb
  begin
    flags_nxt = flags_r;
    if (carry_we)
      flags_nxt[`FLAG_CARRY_BIT] = carry_in;
    if (zero_we)
      flags_nxt[`FLAG_ZERO_BIT] = zero_in;
    if (flag_op_valid)
      flags_nxt = op_result & `FLAG_WRITABLE;
    if (push_valid_r)
      flags_nxt[`FLAG_GIE_BIT] = 1'b0;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flags_r <= `FLAG_RESET;
    else if (restore_now)
      flags_r <= saved_flags_r;
    else if (call_enter)
      flags_r <= flags_r & ~`FLAG_PAGE_MODE_MASK;
    else
      flags_r <= flags_nxt;
  end
  assign page_mode = flags_r[`FLAG_PM_HI:`FLAG_PM_LO];
  assign register_bank_select = flags_r[`FLAG_BANK_BIT];
  assign carry_flag = flags_r[`FLAG_CARRY_BIT];
  assign zero_flag = flags_r[`FLAG_ZERO_BIT];
  assign global_interrupt_enable = flags_r[`FLAG_GIE_BIT];
  // ==========================================================
  // register read
  assign reg_full_addr = {register_bank_select, reg_addr};
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_hit_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      // bank bit ignored: the flags answer in both banks
      rd_hit_r <= reg_rd && (reg_addr == `FLAG_REG_ADDR);
      if (reg_rd && (reg_addr == `FLAG_REG_ADDR))
        rdata_r <= flags_r;
    end
  end
  assign reg_rd_hit = rd_hit_r;
  assign reg_rdata = rdata_r;
  // ==========================================================
  // interrupt entry
  // no entry while a call runs; the ROM must not be interrupted
  assign irq_take = global_interrupt_enable && irq_req && instr_boundary &&
                    !push_valid_r && (state_r == CALL_IDLE) &&
                    !boot_pending_r;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      push_valid_r <= 1'b0;
      push_data_r <= 8'h00;
    end
    else
    begin
      push_valid_r <= irq_take;
      if (irq_take)
        push_data_r <= flags_r;
    end
  end
  assign flags_push_valid = push_valid_r;
  assign flags_push_data = push_data_r;
  // ==========================================================
  // page selection
  always_comb
  begin
    direct_page = (page_mode == 2'b00) ? '0 : current_page_pointer;
    indexed_page = (page_mode == 2'b00) ? '0 :
                   (page_mode[1] ? index_page_pointer : current_page_pointer);
    stack_page = page_mode[0] ? index_page_pointer : stack_page_pointer;
  end
  // indirect pointers bypass page mode, so buffers may sit anywhere
  assign buffer_read_page = indirect_read_page;
  assign buffer_write_page = indirect_write_page;
  // ==========================================================
  // supervisory call sequencer
  // reset acts as a call with the accumulator at its reset value
  assign call_enter = (state_r == CALL_IDLE) && !push_valid_r &&
                      (boot_pending_r ||
                       (opcode_valid && (opcode == `SVC_OPCODE)));
  assign restore_now = (state_r == CALL_RUN) && rom_done;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      boot_pending_r <= 1'b1;
    else if (call_enter)
      boot_pending_r <= 1'b0;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      func_r <= `ACC_RESET;
      sp_r <= 8'h00;
      saved_flags_r <= `FLAG_RESET;
    end
    else if (call_enter)
    begin
      func_r <= boot_pending_r ? `ACC_RESET : accumulator;
      sp_r <= stack_pointer;
      saved_flags_r <= flags_r;
    end
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      first_call_key_r <= 8'h00;
    else if (state_r == CALL_SECOND_CALL_KEY)
      first_call_key_r <= sram_rdata;
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= CALL_IDLE;
      sram_rd <= 1'b0;
      sram_wr <= 1'b0;
      sram_addr <= 8'h00;
      sram_wdata <= 8'h00;
      rom_start <= 1'b0;
      rom_function <= 8'h00;
    end
    else
    begin
      sram_rd <= 1'b0;
      sram_wr <= 1'b0;
      rom_start <= 1'b0;
      unique case (state_r)
        CALL_IDLE:
          if (call_enter)
          begin
            if (boot_pending_r || (accumulator == `FN_BOOT_RESET))
            begin
              rom_start <= 1'b1;
              rom_function <= `FN_BOOT_RESET;
              state_r <= CALL_RUN;
            end
            else
            begin
              sram_rd <= 1'b1;
              sram_addr <= `FIRST_CALL_KEY_SRAM_ADDR;
              state_r <= CALL_FIRST_CALL_KEY;
            end
          end
        CALL_FIRST_CALL_KEY:
        begin
          sram_rd <= 1'b1;
          sram_addr <= `SECOND_CALL_KEY_SRAM_ADDR;
          state_r <= CALL_SECOND_CALL_KEY;
        end
        CALL_SECOND_CALL_KEY:
          state_r <= CALL_CHECK;
        CALL_CHECK:
          if (chk_bus.code_defined && chk_bus.keys_ok)
          begin
            rom_start <= 1'b1;
            rom_function <= func_r;
            state_r <= CALL_RUN;
          end
          else
          begin
            // fatal code left behind for a debugger to find
            sram_wr <= 1'b1;
            sram_addr <= `FIRST_CALL_KEY_SRAM_ADDR;
            sram_wdata <= `RESULT_FATAL;
            state_r <= CALL_HALT;
          end
        CALL_RUN:
          if (rom_done)
          begin
            if (chk_bus.has_result)
            begin
              sram_wr <= 1'b1;
              sram_addr <= `FIRST_CALL_KEY_SRAM_ADDR;
              sram_wdata <= rom_result;
            end
            state_r <= CALL_WB;
          end
        CALL_WB:
          state_r <= (chk_bus.has_result && (sram_wdata == `RESULT_FATAL)) ?
                     CALL_HALT : CALL_IDLE;
        CALL_HALT:
          state_r <= CALL_HALT;
      endcase
    end
  end
  assign call_busy = (state_r != CALL_IDLE) || boot_pending_r;
  assign core_halted = (state_r == CALL_HALT);

endmodule : flag_unit

`default_nettype wire

// *** bench/flag_unit_properties.sv ***
/*
  Port checker of the flag unit: flag reads, interrupt entry, call entry.
  Assumes it is bound onto flag_unit and finds the params header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flag_params.svh"

module flag_unit_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register read port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_full_addr,
  input wire logic reg_rd_hit,
  input wire logic [7:0] reg_rdata,
  // flags
  input wire logic [1:0] page_mode,
  input wire logic register_bank_select,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic global_interrupt_enable,
  // interrupt entry
  input wire logic instr_boundary,
  input wire logic irq_req,
  input wire logic irq_take,
  input wire logic flags_push_valid,
  input wire logic [7:0] flags_push_data,
  // supervisory call
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] accumulator,
  input wire logic sram_rd,
  input wire logic [7:0] sram_addr,
  input wire logic rom_start,
  input wire logic [7:0] rom_function,
  input wire logic call_busy,
  input wire logic core_halted
);
  // ==========================================================
  // helpers
  wire logic [7:0] flags_now = {page_mode, 1'b0, register_bank_select, 1'b0,
    carry_flag, zero_flag, global_interrupt_enable};
  // push pending also blocks entry, so keep it out of the antecedent
  wire logic call_go = opcode_valid && opcode == `SVC_OPCODE && !call_busy
    && !core_halted && !irq_take && !flags_push_valid;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence push_seq;
    flags_push_valid && flags_push_data == $past(flags_now);
  endsequence
  sequence key_reads;
    sram_rd && sram_addr == `FIRST_CALL_KEY_SRAM_ADDR ##1 sram_rd && sram_addr == `SECOND_CALL_KEY_SRAM_ADDR;
  endsequence

  // ==========================================================
  // properties
  a_read_hit: assert property (reg_rd && reg_addr == `FLAG_REG_ADDR
    |=> reg_rd_hit && reg_rdata == $past(flags_now))
    else $error("flag read data wrong");
  a_read_miss: assert property (!(reg_rd && reg_addr == `FLAG_REG_ADDR) |=> !reg_rd_hit)
    else $error("flag read hit without request");
  a_rsvd_zero: assert property (reg_rd_hit |-> !reg_rdata[5] && !reg_rdata[3])
    else $error("reserved flag bit set");
  a_full_addr: assert property (reg_full_addr == {register_bank_select, reg_addr})
    else $error("bank bit not in register address");
  a_push_clear: assert property (irq_take |=> push_seq ##1 !global_interrupt_enable)
    else $error("interrupt push or enable clear wrong");
  a_irq_gate: assert property (irq_take |-> global_interrupt_enable && irq_req
    && instr_boundary)
    else $error("interrupt taken while disabled");
  a_key_reads: assert property (call_go && accumulator != 8'h00 |=> key_reads)
    else $error("call keys not read");
  a_boot_direct: assert property (call_go && accumulator == 8'h00
    |=> rom_start && rom_function == `FN_BOOT_RESET && !sram_rd)
    else $error("boot call wrong");
  a_page_zero: assert property (rom_start |-> page_mode == 2'b00)
    else $error("page mode kept in call");
  a_halt_holds: assert property (core_halted |=> core_halted)
    else $error("halt released without reset");
endmodule : flag_unit_properties

bind flag_unit flag_unit_properties u_props (
  .core_clk, .rst, .reg_addr, .reg_rd, .reg_full_addr, .reg_rd_hit, .reg_rdata,
  .page_mode, .register_bank_select, .carry_flag, .zero_flag, .global_interrupt_enable,
  .instr_boundary, .irq_req, .irq_take, .flags_push_valid, .flags_push_data,
  .opcode_valid, .opcode, .accumulator, .sram_rd, .sram_addr, .rom_start,
  .rom_function, .call_busy, .core_halted
);

`default_nettype wire

// *** bench/flag_unit_bench.sv ***
/*
  Self-checking bench of the flag unit; bench plays core, SRAM and ROM.
  Assumes the flag unit sources and params header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flag_params.svh"

module flag_unit_bench;
  import flag_pkg::*;
  // ==========================================================
  // signals
  logic core_clk = 0, rst = 1, reg_rd = 0, flag_op_valid = 0, carry_we = 0, carry_in = 0;
  logic zero_we = 0, zero_in = 0, instr_boundary = 0, irq_req = 0, opcode_valid = 0;
  logic rom_done = 0;
  flag_op_t flag_op = FLAG_AND;
  logic [7:0] reg_addr = 0, flag_op_mask = 0, opcode = 0, accumulator = 0;
  logic [7:0] stack_pointer = 0, sram_rdata = 0, rom_result = 0;
  logic [2:0] current_page_pointer = 0, stack_page_pointer = 0, index_page_pointer = 0;
  logic [2:0] indirect_read_page = 0, indirect_write_page = 0;
  logic [2:0] direct_page, indexed_page, stack_page, buffer_read_page, buffer_write_page;
  logic [8:0] reg_full_addr;
  logic [7:0] reg_rdata, flags_push_data, sram_addr, sram_wdata, rom_function;
  logic [1:0] page_mode;
  logic reg_rd_hit, irq_take, flags_push_valid, register_bank_select, carry_flag;
  logic zero_flag, global_interrupt_enable, sram_rd, sram_wr, rom_start, call_busy;
  logic core_halted;
  logic [7:0] qr[$], qw[$], qm[$], qp[$];
  logic [7:0] exp_f, k1, k2, pend;
  logic [31:0] seed = 32'hafd6;
  int err_total = 0, n_tests = 0, cyc = 0;

  flag_unit #(.PAGE_W(3)) u_dut (
    .core_clk, .rst, .reg_addr, .reg_rd, .reg_full_addr, .reg_rd_hit, .reg_rdata,
    .flag_op_valid, .flag_op, .flag_op_mask, .carry_we, .carry_in, .zero_we, .zero_in,
    .instr_boundary, .irq_req, .irq_take, .flags_push_valid, .flags_push_data,
    .page_mode, .register_bank_select, .carry_flag, .zero_flag, .global_interrupt_enable,
    .current_page_pointer, .stack_page_pointer, .index_page_pointer, .indirect_read_page,
    .indirect_write_page, .direct_page, .indexed_page, .stack_page, .buffer_read_page,
    .buffer_write_page, .opcode_valid, .opcode, .accumulator, .stack_pointer, .sram_rd,
    .sram_wr, .sram_addr, .sram_wdata, .sram_rdata, .rom_start, .rom_function, .rom_done,
    .rom_result, .call_busy, .core_halted
  );

  initial forever #12.5 core_clk = ~core_clk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_of_test();
    err_total += qr.size() + qw.size() + qm.size() + qp.size();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic take(ref logic [7:0] q[$], input logic [7:0] got);
    if (q.size() == 0)
      chk(9'h1ff, {1'b0, got});
    else
      chk({1'b0, got}, {1'b0, q.pop_front()});
  endtask : take

  // bounded wait that also counts as a comparison
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({8'h0, s}, {8'h0, v});
  endtask : wt

  task rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1;
    if (a == `FLAG_REG_ADDR) qr.push_back(exp_f);
    #1 chk(reg_full_addr, {exp_f[4], a});
    @(negedge core_clk);
    reg_rd = 0;
    @(negedge core_clk);
  endtask : rd

  task fop(input flag_op_t op, input logic [7:0] m);
    flag_op = op;
    flag_op_mask = m & `FLAG_WRITABLE;
    flag_op_valid = 1;
    @(negedge core_clk);
    flag_op_valid = 0;
    case (op)
      FLAG_AND: exp_f = exp_f & flag_op_mask;
      FLAG_OR: exp_f = exp_f | flag_op_mask;
      default: exp_f = exp_f ^ flag_op_mask;
    endcase
    @(negedge core_clk);
  endtask : fop

  task do_reset();
    rst = 1;
    repeat (16) @(negedge core_clk);
    exp_f = `FLAG_RESET;
    qm.push_back(`FN_BOOT_RESET);
    qw.push_back(`RESULT_SUCCESS);
    rst = 0;
    wt(rom_start, 1'b1);
    rom_done = 1;
    rom_result = `RESULT_SUCCESS;
    @(negedge core_clk);
    rom_done = 0;
    rom_result = 8'hff;
    wt(call_busy, 1'b0);
    rd(`FLAG_REG_ADDR);
  endtask : do_reset

  // kind 0 good keys, 1 bad first key, 2 bad second key
  task automatic call(input logic [7:0] fn, input logic [7:0] res, input int kind);
    logic bad;
    stack_pointer = 8'(rnd());
    k1 = kind == 1 ? 8'h3b : `FIRST_CALL_KEY_EXPECTED;
    k2 = stack_pointer + (kind == 2 ? 8'h02 : `SECOND_CALL_KEY_SP_OFFSET);
    bad = fn > 8'h09 || fn == 8'h04 || fn == 8'h05 || (fn != 8'h00 && kind != 0);
    fop(FLAG_OR, 8'hc4);
    if (bad) qw.push_back(`RESULT_FATAL);
    else qm.push_back(fn);
    opcode = `SVC_OPCODE;
    accumulator = fn;
    opcode_valid = 1;
    @(negedge core_clk);
    opcode_valid = 0;
    if (bad)
    begin
      wt(core_halted, 1'b1);
      repeat (8) @(negedge core_clk);
      opcode_valid = 1;
      @(negedge core_clk);
      opcode_valid = 0;
      repeat (8) @(negedge core_clk);
      chk({8'h0, core_halted}, 9'h001);
      do_reset();
    end
    else
    begin
      wt(rom_start, 1'b1);
      repeat (rnd() % 4) @(negedge core_clk);
      if (fn != `FN_TABLE_FETCH && fn != `FN_CHECKSUM) qw.push_back(res);
      rom_done = 1;
      rom_result = res;
      @(negedge core_clk);
      rom_done = 0;
      rom_result = ~res;
      if (res == `RESULT_FATAL && fn != `FN_TABLE_FETCH && fn != `FN_CHECKSUM)
      begin
        wt(core_halted, 1'b1);
        do_reset();
      end
      else
      begin
        wt(call_busy, 1'b0);
        rd(`FLAG_REG_ADDR);
      end
    end
  endtask : call

  // ==========================================================
  // SRAM with one cycle latency, churning when idle
  always @(negedge core_clk)
  begin
    sram_rdata <= pend;
    pend <= sram_rd === 1'b1 ? (sram_addr == `FIRST_CALL_KEY_SRAM_ADDR ? k1 : k2) : ~pend;
  end

  // ==========================================================
  // monitor
  always @(negedge core_clk)
  begin
    if (reg_rd_hit === 1'b1) take(qr, reg_rdata);
    if (flags_push_valid === 1'b1) take(qp, flags_push_data);
    if (rom_start === 1'b1) take(qm, rom_function);
    if (rom_start === 1'b1) chk({7'h0, page_mode}, 9'h000);
    if (sram_wr === 1'b1) take(qw, sram_wdata);
    if (sram_wr === 1'b1) chk({1'b0, sram_addr}, {1'b0, `FIRST_CALL_KEY_SRAM_ADDR});
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    do_reset();
    rd(8'hf6);
    fop(FLAG_OR, 8'h10);
    rd(`FLAG_REG_ADDR);
    for (int i = 0; i < 12; i++)
    begin
      fop(flag_op_t'(rnd() % 3), 8'(rnd()));
      rd(`FLAG_REG_ADDR);
    end
    fop(FLAG_AND, 8'h00);
    carry_we = 1;
    carry_in = 1;
    zero_we = 1;
    @(negedge core_clk);
    carry_we = 0;
    zero_we = 0;
    exp_f[2] = 1'b1;
    exp_f[1] = 1'b0;
    rd(`FLAG_REG_ADDR);
    fop(FLAG_OR, 8'h01);
    qp.push_back(exp_f);
    irq_req = 1;
    instr_boundary = 1;
    #1 chk({8'h0, irq_take}, 9'h001);
    @(negedge core_clk);
    instr_boundary = 0;
    @(negedge core_clk);
    exp_f[0] = 1'b0;
    rd(`FLAG_REG_ADDR);
    instr_boundary = 1;
    #1 chk({8'h0, irq_take}, 9'h000);
    @(negedge core_clk);
    instr_boundary = 0;
    irq_req = 0;
    for (int m = 0; m < 4; m++)
    begin
      {current_page_pointer, stack_page_pointer, index_page_pointer} = 9'(rnd());
      {indirect_read_page, indirect_write_page} = 6'(rnd());
      fop(FLAG_AND, 8'h3f);
      fop(FLAG_OR, 8'(m << 6));
      chk({6'h0, direct_page}, m == 0 ? 9'h0 : {6'h0, current_page_pointer});
      chk({6'h0, indexed_page}, m == 0 ? 9'h0
        : {6'h0, m > 1 ? index_page_pointer : current_page_pointer});
      chk({6'h0, stack_page}, {6'h0, m % 2 ? index_page_pointer : stack_page_pointer});
      chk({3'h0, buffer_read_page, buffer_write_page},
        {3'h0, indirect_read_page, indirect_write_page});
    end
    for (int f = 0; f < 11; f++)
      call(8'(f), 8'(rnd() % 3), 0);
    call(`FN_BLOCK_FETCH, `RESULT_SUCCESS, 1);
    call(`FN_BLOCK_PROGRAM, `RESULT_SUCCESS, 2);
    call(`FN_BOOT_RESET, `RESULT_SW_RESET, 1);
    call(`FN_BLOCK_CLEAR, `RESULT_FATAL, 0);
    end_of_test();
  end
endmodule : flag_unit_bench

`default_nettype wire
